// ---- core/ecf_pkg.sv ----
package ecf_pkg;

  // ----------------------------------------------------------------
  // Link timing.
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BAUD = 9600;
  localparam logic [11:0] BIT_CYC = 12'(CLK_HZ / BAUD);
  localparam logic [11:0] HALF_CYC = 12'(CLK_HZ / BAUD / 2);
  localparam logic [11:0] CNT_ZERO = 12'h000;
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic IDLE_LEVEL = 1'b1;

  // ----------------------------------------------------------------
  // Transaction shape.
  // ----------------------------------------------------------------
  localparam logic [2:0] REPLY_LAST = 3'h4;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Command codes.
  // ----------------------------------------------------------------
  localparam logic [7:0] CUSTOM_LO = 8'hdc;
  localparam logic [7:0] CUSTOM_HI = 8'he5;
  localparam logic [7:0] POSITION_QUERY_CMD = 8'h42;
  localparam logic [7:0] MARKER_UPDOWN_CMD = 8'h81;
  localparam logic [7:0] COLOUR_COLOUR_EXPANSION_FLAG_LEFT_CMD = 8'h30;
  localparam logic [7:0] COLOUR_COLOUR_EXPANSION_FLAG_RIGHT_CMD = 8'h31;
  localparam logic [7:0] EXPANSION_ENABLE_CMD = 8'hd0;
  localparam logic [7:0] POSITION_EXP_INIT_CMD = 8'hd1;
  localparam logic [7:0] MARKER_EXP_INIT_CMD = 8'hd2;
  localparam logic [7:0] ORIGIN_X_HIGH_CMD = 8'hd3;
  localparam logic [7:0] ORIGIN_X_LOW_CMD = 8'hd4;
  localparam logic [7:0] ORIGIN_Y_HIGH_CMD = 8'hd5;
  localparam logic [7:0] ORIGIN_Y_LOW_CMD = 8'hd6;

  // ----------------------------------------------------------------
  // Bits of the expansion enable parameter.
  // ----------------------------------------------------------------
  localparam int unsigned EN_MARKER = 0;
  localparam int unsigned EN_COLOUR = 1;
  localparam int unsigned EN_POSITION = 2;

endpackage : ecf_pkg

// ---- core/ecf_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// Shared expansion link: one driven forward line, one open-drain return line.
interface ecf_link_if;
  logic fwd_line;
  logic ret_o;
  logic ret_oe;
  logic ret_line;

  // The pull-up holds the return line high unless an expansion pulls it low.
  assign ret_line = !(ret_oe && !ret_o);

  modport ctl (output fwd_line, input ret_line);
  modport exp (input fwd_line, output ret_o, output ret_oe, input ret_line);
endinterface : ecf_link_if

`default_nettype wire

// ---- core/ecf_uart.sv ----
`timescale 1ns/1ps
`default_nettype none

// Byte serialiser and deserialiser, eight data bits, no parity, one stop bit.
module ecf_uart (
  input wire logic i_clk,          // System clock.
  input wire logic i_nrst,         // Asynchronous reset, active low.
  input wire logic i_tx_valid,     // Byte offered for sending.
  input wire logic [7:0] i_tx_data, // Byte to send.
  output logic o_tx_ready,         // Transmitter idle.
  output logic o_tx_line,          // Serial output, registered.
  input wire logic i_rx_line,      // Serial input.
  output logic o_rx_valid,         // One-cycle pulse with a received byte.
  output logic [7:0] o_rx_data     // Received byte.
);

  typedef enum logic [1:0] {ECF_RX_IDLE, ECF_RX_START, ECF_RX_DATA, ECF_RX_STOP} ecf_rx_t;

  logic [9:0] tx_sh, next_tx_sh;
  logic [3:0] tx_left, next_tx_left;
  logic [11:0] tx_cnt, next_tx_cnt;
  ecf_rx_t rx_st, next_rx_st;
  logic [11:0] rx_cnt, next_rx_cnt;
  logic [3:0] rx_n, next_rx_n;
  logic [7:0] rx_sh, next_rx_sh;
  logic next_rx_valid;

  // ----------------------------------------------------------------
  // Transmitter.
  // ----------------------------------------------------------------
  assign o_tx_ready = (tx_left == 4'h0);
  assign o_tx_line = tx_sh[0];

  // Frame is start bit, byte LSB first, stop bit; idle shifts in ones. [R18] [R01]
  always_comb begin
    next_tx_sh = tx_sh;
    next_tx_left = tx_left;
    next_tx_cnt = tx_cnt;
    if (tx_left == 4'h0) begin
      if (i_tx_valid) begin
        next_tx_sh = {ecf_pkg::IDLE_LEVEL, i_tx_data, 1'b0};
        next_tx_left = ecf_pkg::FRAME_BITS;
        next_tx_cnt = ecf_pkg::BIT_CYC - 12'h001;
      end
    end else if (tx_cnt == ecf_pkg::CNT_ZERO) begin
      next_tx_sh = {ecf_pkg::IDLE_LEVEL, tx_sh[9:1]};
      next_tx_left = tx_left - 4'h1;
      next_tx_cnt = ecf_pkg::BIT_CYC - 12'h001;
    end else begin
      next_tx_cnt = tx_cnt - 12'h001;
    end
  end

  // Reset fills the shifter with ones so the line rests at the idle level.

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_sh <= 10'h3ff;
      tx_left <= 4'h0;
      tx_cnt <= 12'h000;
    end else begin
      tx_sh <= next_tx_sh;
      tx_left <= next_tx_left;
      tx_cnt <= next_tx_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Receiver.
  // ----------------------------------------------------------------
  // Samples mid-bit; a low stop bit drops the byte as a framing error. [R18]
  always_comb begin
    next_rx_st = rx_st;
    next_rx_cnt = rx_cnt;
    next_rx_n = rx_n;
    next_rx_sh = rx_sh;
    next_rx_valid = 1'b0;
    if (rx_st != ECF_RX_IDLE) begin
      next_rx_cnt = rx_cnt - 12'h001;
    end
    unique case (rx_st)
      ECF_RX_IDLE: begin
        if (!i_rx_line) begin
          next_rx_st = ECF_RX_START;
          next_rx_cnt = ecf_pkg::HALF_CYC;
        end
      end
      ECF_RX_START: begin
        if (rx_cnt == ecf_pkg::CNT_ZERO) begin
          next_rx_st = i_rx_line ? ECF_RX_IDLE : ECF_RX_DATA;
          next_rx_cnt = ecf_pkg::BIT_CYC - 12'h001;
          next_rx_n = 4'h0;
        end
      end
      ECF_RX_DATA: begin
        if (rx_cnt == ecf_pkg::CNT_ZERO) begin
          next_rx_sh = {i_rx_line, rx_sh[7:1]};
          next_rx_n = rx_n + 4'h1;
          next_rx_cnt = ecf_pkg::BIT_CYC - 12'h001;
          if (rx_n == ecf_pkg::LAST_DATA_BIT) begin
            next_rx_st = ECF_RX_STOP;
          end
        end
      end
      ECF_RX_STOP: begin
        if (rx_cnt == ecf_pkg::CNT_ZERO) begin
          next_rx_valid = i_rx_line;
          next_rx_st = ECF_RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_st <= ECF_RX_IDLE;
      rx_cnt <= 12'h000;
      rx_n <= 4'h0;
      rx_sh <= 8'h00;
      o_rx_valid <= 1'b0;
    end else begin
      rx_st <= next_rx_st;
      rx_cnt <= next_rx_cnt;
      rx_n <= next_rx_n;
      rx_sh <= next_rx_sh;
      o_rx_valid <= next_rx_valid;
    end
  end

  assign o_rx_data = rx_sh;

endmodule : ecf_uart

`default_nettype wire

// ---- core/ecf_controller.sv ----
// Contract
// [R01] Link runs asynchronous serial at 9600 baud.
// [R02] Two command bytes out, five reply bytes back.
// [R03] Codes 220 to 229 are custom, not local.
// [R04] Custom command bytes resent unchanged on link.
// [R05] Wait five reply bytes, relay them unmodified.
// [R06] Marker, colour, position forwarded only when enabled.
// [R07] Position expansion answers query code 66.
// [R08] Position reply: x bytes one-two, y three-four.
// [R09] Coordinates are unsigned sixteen-bit values.
// [R10] Position init command forwarded with both bytes.
// [R11] Expansion takes origin commands as start position.
// [R12] Marker expansion moves pen on code 129.
// [R13] Expansion always replies five bytes, zeros default.
// [R14] Expansion parses byte pairs, acts on own codes.
// [R15] Marker init command forwarded to the link.
// [R16] Expansion return line driven low, released high.
// [R17] Expansion silent for commands not its own.
// [R18] Bytes are eight data bits, no parity, one stop.
`timescale 1ns/1ps
`default_nettype none

module ecf_controller (
  input wire logic i_clk,            // System clock.
  input wire logic i_nrst,           // Asynchronous reset, active low.
  ecf_link_if.ctl link,              // Expansion link.
  input wire logic i_cmd_valid,      // Host command offered.
  input wire logic [7:0] i_cmd_code, // Host command code byte.
  input wire logic [7:0] i_cmd_param, // Host command parameter byte.
  output logic o_cmd_ready,          // Ready for a host command.
  output logic o_rsp_valid,          // One-cycle pulse, reply ready.
  output logic [39:0] o_rsp_data,    // Reply bytes, first byte in top bits.
  output logic o_local_valid,        // One-cycle pulse, command kept local.
  output logic [7:0] o_local_code,   // Code of the local command.
  output logic [7:0] o_local_param,  // Parameter of the local command.
  output logic [2:0] o_enable_mask   // Enabled expansion types.
);

  typedef enum logic [2:0] {ECF_IDLE, ECF_SEND_CODE, ECF_SEND_PARAM, ECF_WAIT, ECF_DONE} ecf_st_t;

  // ----------------------------------------------------------------
  // State and next values.
  // ----------------------------------------------------------------
  // Code and parameter are latched at the take, so the host may change them after.
  ecf_st_t st, next_st;
  logic [7:0] code, next_code;
  logic [7:0] param, next_param;
  logic [2:0] idx, next_idx;
  logic [39:0] next_rsp_data;
  logic next_rsp_valid;
  logic next_cmd_ready;
  logic next_local_valid;
  logic [7:0] next_local_code;
  logic [7:0] next_local_param;
  logic [2:0] next_enable_mask;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_ready;
  logic rx_valid;
  logic [7:0] rx_data;

  // ----------------------------------------------------------------
  // Command classification.
  // ----------------------------------------------------------------
  // Custom range is matched inclusively at both ends. [R03]
  function automatic logic ecf_is_custom(input logic [7:0] c);
    ecf_is_custom = (c >= ecf_pkg::CUSTOM_LO) && (c <= ecf_pkg::CUSTOM_HI);
  endfunction : ecf_is_custom

  // Decides whether a code goes to the link under the given enable mask.
  function automatic logic ecf_forwards(input logic [7:0] c, input logic [2:0] m);
    logic mk;
    logic cl;
    logic ps;
    // Init and origin commands share the enable bit of their expansion type.
    mk = (c == ecf_pkg::MARKER_UPDOWN_CMD) || (c == ecf_pkg::MARKER_EXP_INIT_CMD);
    cl = (c == ecf_pkg::COLOUR_COLOUR_EXPANSION_FLAG_LEFT_CMD) || (c == ecf_pkg::COLOUR_COLOUR_EXPANSION_FLAG_RIGHT_CMD);
    ps = (c == ecf_pkg::POSITION_QUERY_CMD) || (c == ecf_pkg::POSITION_EXP_INIT_CMD) ||
         (c == ecf_pkg::ORIGIN_X_HIGH_CMD) || (c == ecf_pkg::ORIGIN_X_LOW_CMD) ||
         (c == ecf_pkg::ORIGIN_Y_HIGH_CMD) || (c == ecf_pkg::ORIGIN_Y_LOW_CMD);
    ecf_forwards = ecf_is_custom(c) ||                      // [R03] [R04]
                   (mk && m[ecf_pkg::EN_MARKER]) ||         // [R06] [R15]
                   (cl && m[ecf_pkg::EN_COLOUR]) ||         // [R06]
                   (ps && m[ecf_pkg::EN_POSITION]);         // [R06] [R10]
  endfunction : ecf_forwards

  // ----------------------------------------------------------------
  // Serial port toward the expansions.
  // ----------------------------------------------------------------
  // One port serves both directions; the return line idles high on its pull-up.
  ecf_uart u_uart (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tx_valid(tx_valid),
    .i_tx_data(tx_data),
    .o_tx_ready(tx_ready),
    .o_tx_line(link.fwd_line),
    .i_rx_line(link.ret_line),
    .o_rx_valid(rx_valid),
    .o_rx_data(rx_data)
  );

  // Code goes first, then parameter, both exactly as the host sent them. [R02] [R04]
  assign tx_valid = (st == ECF_SEND_CODE) || (st == ECF_SEND_PARAM);
  assign tx_data = (st == ECF_SEND_CODE) ? code : param;

  // ----------------------------------------------------------------
  // Transaction sequencer.
  // ----------------------------------------------------------------
  // There is no reply timeout: a missing expansion stalls the host port.
  // That keeps replies strictly paired with commands at the cost of liveness.
  always_comb begin
    next_st = st;
    next_code = code;
    next_param = param;
    next_idx = idx;
    next_rsp_data = o_rsp_data;
    next_rsp_valid = 1'b0;
    next_local_valid = 1'b0;
    next_local_code = o_local_code;
    next_local_param = o_local_param;
    next_enable_mask = o_enable_mask;
    unique case (st)
      ECF_IDLE: begin
        if (i_cmd_valid) begin
          next_code = i_cmd_code;
          next_param = i_cmd_param;
          if (ecf_forwards(i_cmd_code, o_enable_mask)) begin
            next_st = ECF_SEND_CODE;                        // [R04] [R06]
          end else begin
            next_local_valid = 1'b1;
            next_local_code = i_cmd_code;
            next_local_param = i_cmd_param;
            // The enable command stays local; it also reloads the mask.
            if (i_cmd_code == ecf_pkg::EXPANSION_ENABLE_CMD) begin
              next_enable_mask = i_cmd_param[2:0];          // [R06]
            end
          end
        end
      end
      ECF_SEND_CODE: begin
        if (tx_ready) begin
          next_st = ECF_SEND_PARAM;                         // [R02]
        end
      end
      ECF_SEND_PARAM: begin
        if (tx_ready) begin
          next_st = ECF_WAIT;
          // The reply count restarts as the parameter frame begins.
          next_idx = 3'h0;
        end
      end
      ECF_WAIT: begin
        // Bytes shift in so the first reply byte lands in the top bits. [R05]
        if (rx_valid) begin
          next_rsp_data = {o_rsp_data[31:0], rx_data};
          next_idx = idx + 3'h1;
          if (idx == ecf_pkg::REPLY_LAST) begin
            next_st = ECF_DONE;                             // [R02] [R05]
          end
        end
      end
      ECF_DONE: begin
        // The extra state lets the fifth byte settle in the reply word first.
        next_rsp_valid = 1'b1;                              // [R05]
        next_st = ECF_IDLE;
      end
      default: begin
        next_st = ECF_IDLE;
      end
    endcase
    // Ready follows the next state, so it drops at the very edge that takes a forwarded command; a local command leaves it high.
    next_cmd_ready = (next_st == ECF_IDLE);
  end

  // Registers only; every host output leaves a flop, so the host sees no glitch.
  // Reset leaves the port ready and every expansion type disabled.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= ECF_IDLE;
      code <= 8'h00;
      param <= 8'h00;
      idx <= 3'h0;
      o_rsp_data <= 40'h00_0000_0000;
      o_rsp_valid <= 1'b0;
      o_cmd_ready <= 1'b1;
      o_local_valid <= 1'b0;
      o_local_code <= 8'h00;
      o_local_param <= 8'h00;
      o_enable_mask <= 3'h0;
    end else begin
      st <= next_st;
      code <= next_code;
      param <= next_param;
      idx <= next_idx;
      o_rsp_data <= next_rsp_data;
      o_rsp_valid <= next_rsp_valid;
      o_cmd_ready <= next_cmd_ready;
      o_local_valid <= next_local_valid;
      o_local_code <= next_local_code;
      o_local_param <= next_local_param;
      o_enable_mask <= next_enable_mask;
    end
  end

endmodule : ecf_controller

`default_nettype wire

// ---- core/ecf_expansion.sv ----
`timescale 1ns/1ps
`default_nettype none

// Combined position and marker expansion on the shared link.
module ecf_expansion (
  input wire logic i_clk,            // System clock.
  input wire logic i_nrst,           // Asynchronous reset, active low.
  ecf_link_if.exp link,              // Expansion link.
  input wire logic [15:0] i_move_x,  // Travel in x since the origin.
  input wire logic [15:0] i_move_y,  // Travel in y since the origin.
  output logic o_marker_down,        // Pen lowered, registered level.
  output logic [7:0] o_pos_setup,    // Last position init parameter.
  output logic [7:0] o_marker_setup, // Last marker init parameter.
  output logic [15:0] o_origin_x,    // Start x coordinate.
  output logic [15:0] o_origin_y,    // Start y coordinate.
  output logic o_sample              // One-cycle pulse on a position query.
);

  typedef enum logic [1:0] {ECF_X_CODE, ECF_X_PARAM, ECF_X_REPLY} ecf_xst_t;

  ecf_xst_t st, next_st;
  logic [7:0] code, next_code;
  logic [39:0] reply, next_reply;
  logic [2:0] idx, next_idx;
  logic [15:0] pos_x;
  logic [15:0] pos_y;
  logic [15:0] next_origin_x, next_origin_y;
  logic [7:0] next_pos_setup, next_marker_setup;
  logic next_marker_down, next_sample;
  logic tx_valid, tx_ready, tx_line, rx_valid;
  logic [7:0] rx_data;
  logic mine;
  logic next_oe;

  ecf_uart u_uart (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tx_valid(tx_valid),
    .i_tx_data(reply[39:32]),
    .o_tx_ready(tx_ready),
    .o_tx_line(tx_line),
    .i_rx_line(link.fwd_line),
    .o_rx_valid(rx_valid),
    .o_rx_data(rx_data)
  );

  // Unsigned wrap-around position; there is no negative encoding. [R09] [R11]
  assign pos_x = o_origin_x + i_move_x;
  assign pos_y = o_origin_y + i_move_y;
  assign tx_valid = (st == ECF_X_REPLY);

  // Only codes served here get an answer; any other pair passes silently. [R14] [R17]
  assign mine = (code == ecf_pkg::POSITION_QUERY_CMD) || (code == ecf_pkg::MARKER_UPDOWN_CMD) ||
                (code == ecf_pkg::POSITION_EXP_INIT_CMD) || (code == ecf_pkg::MARKER_EXP_INIT_CMD) ||
                (code == ecf_pkg::ORIGIN_X_HIGH_CMD) || (code == ecf_pkg::ORIGIN_X_LOW_CMD) ||
                (code == ecf_pkg::ORIGIN_Y_HIGH_CMD) || (code == ecf_pkg::ORIGIN_Y_LOW_CMD);

  // ----------------------------------------------------------------
  // Pair parser and reply sender.
  // ----------------------------------------------------------------
  // A lost byte shifts the pairing until a stray byte realigns it.
  always_comb begin
    next_st = st;
    next_code = code;
    next_reply = reply;
    next_idx = idx;
    next_origin_x = o_origin_x;
    next_origin_y = o_origin_y;
    next_pos_setup = o_pos_setup;
    next_marker_setup = o_marker_setup;
    next_marker_down = o_marker_down;
    next_sample = 1'b0;
    unique case (st)
      ECF_X_CODE: begin
        if (rx_valid) begin
          next_code = rx_data;                              // [R14]
          next_st = ECF_X_PARAM;
        end
      end
      ECF_X_PARAM: begin
        if (rx_valid) begin
          next_st = mine ? ECF_X_REPLY : ECF_X_CODE;        // [R14] [R17]
          next_idx = 3'h0;
          next_reply = {5{ecf_pkg::ZERO_BYTE}};             // [R13]
          unique case (code)
            ecf_pkg::POSITION_QUERY_CMD: begin
              next_sample = 1'b1;                           // [R07]
              next_reply = {pos_x, pos_y, ecf_pkg::ZERO_BYTE}; // [R08]
            end
            ecf_pkg::MARKER_UPDOWN_CMD: next_marker_down = (rx_data != ecf_pkg::ZERO_BYTE); // [R12]
            ecf_pkg::POSITION_EXP_INIT_CMD: next_pos_setup = rx_data;
            ecf_pkg::MARKER_EXP_INIT_CMD: next_marker_setup = rx_data;
            ecf_pkg::ORIGIN_X_HIGH_CMD: next_origin_x = {rx_data, o_origin_x[7:0]}; // [R11]
            ecf_pkg::ORIGIN_X_LOW_CMD: next_origin_x = {o_origin_x[15:8], rx_data}; // [R11]
            ecf_pkg::ORIGIN_Y_HIGH_CMD: next_origin_y = {rx_data, o_origin_y[7:0]}; // [R11]
            ecf_pkg::ORIGIN_Y_LOW_CMD: next_origin_y = {o_origin_y[15:8], rx_data}; // [R11]
            default: next_reply = {5{ecf_pkg::ZERO_BYTE}};
          endcase
        end
      end
      ECF_X_REPLY: begin
        if (tx_ready) begin
          next_reply = {reply[31:0], ecf_pkg::ZERO_BYTE};
          next_idx = idx + 3'h1;
          if (idx == ecf_pkg::REPLY_LAST) begin
            next_st = ECF_X_CODE;                           // [R13]
          end
        end
      end
      default: next_st = ECF_X_CODE;
    endcase
    // Pull low for a zero bit, release for a one. [R16]
    next_oe = !tx_line;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= ECF_X_CODE;
      code <= 8'h00;
      reply <= 40'h00_0000_0000;
      idx <= 3'h0;
      o_origin_x <= 16'h0000;
      o_origin_y <= 16'h0000;
      o_pos_setup <= 8'h00;
      o_marker_setup <= 8'h00;
      o_marker_down <= 1'b0;
      o_sample <= 1'b0;
      link.ret_oe <= 1'b0;
    end else begin
      st <= next_st;
      code <= next_code;
      reply <= next_reply;
      idx <= next_idx;
      o_origin_x <= next_origin_x;
      o_origin_y <= next_origin_y;
      o_pos_setup <= next_pos_setup;
      o_marker_setup <= next_marker_setup;
      o_marker_down <= next_marker_down;
      o_sample <= next_sample;
      link.ret_oe <= next_oe;
    end
  end

  assign link.ret_o = 1'b0;

endmodule : ecf_expansion

`default_nettype wire

// ---- test/ecf_link_chk.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Checker on the shared expansion link.
// ----------------------------------------------------------------
module ecf_link_chk (
  input wire logic i_clk,      // System clock.
  input wire logic i_nrst,     // Asynchronous reset, active low.
  input wire logic i_fwd_line, // Forward serial line.
  input wire logic i_ret_o,    // Expansion output value.
  input wire logic i_ret_oe,   // Expansion pulls the return line low.
  input wire logic i_ret_line  // Resolved return line.
);
  int unsigned bit_cyc = ecf_pkg::BIT_CYC;
  int unsigned half_cyc = ecf_pkg::HALF_CYC;
  int unsigned run_f;
  int unsigned run_r;
  logic fwd_q;
  logic oe_q;

  // Run lengths of each level, so bit times can be judged at each rising edge of the line.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      run_f <= 0;
      run_r <= 0;
      fwd_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      run_f <= (i_fwd_line != fwd_q) ? 1 : run_f + 1;
      run_r <= (i_ret_oe != oe_q) ? 1 : run_r + 1;
      fwd_q <= i_fwd_line;
      oe_q <= i_ret_oe;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // A start bit is a held low level, never a glitch.
  sequence s_start;
    $fell(i_fwd_line);
  endsequence
  sequence s_hold;
    !i_fwd_line [*8];
  endsequence

  a_fwd_start_hold: assert property (s_start |-> s_hold)
    else $error("forward start bit too short");
  a_fwd_bit_time: assert property ($rose(i_fwd_line) |-> (run_f % bit_cyc) == 0)
    else $error("forward low run not whole bits");
  a_fwd_low_max: assert property ($rose(i_fwd_line) |-> run_f <= 9 * bit_cyc)
    else $error("forward frame lacks stop bit");
  a_ret_bit_time: assert property ($fell(i_ret_oe) |-> (run_r % bit_cyc) == 0)
    else $error("return low run not whole bits");
  a_ret_low_max: assert property ($fell(i_ret_oe) |-> run_r <= 9 * bit_cyc)
    else $error("return frame lacks stop bit");
  a_ret_drive_low: assert property (i_ret_oe |-> !i_ret_o && !i_ret_line)
    else $error("return line not pulled low");
  a_reply_fwd_quiet: assert property (i_ret_oe |-> i_fwd_line)
    else $error("controller sends during reply");
  a_reply_after_cmd: assert property ($rose(i_ret_oe) |-> i_fwd_line && run_f >= half_cyc)
    else $error("reply starts before command ends");
endmodule : ecf_link_chk

`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Controller and expansion joined over one link.
// ----------------------------------------------------------------
module tb;
  logic i_clk;
  logic i_nrst;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [7:0] cmd_param;
  logic cmd_ready;
  logic rsp_valid;
  logic [39:0] rsp_data;
  logic local_valid;
  logic [7:0] local_code;
  logic [7:0] local_param;
  logic [2:0] enable_mask;
  logic [15:0] move_x;
  logic [15:0] move_y;
  logic marker_down;
  logic [15:0] origin_x;
  logic [15:0] origin_y;
  logic [7:0] pos_setup;
  logic [7:0] marker_setup;
  logic [39:0] ans;
  logic loc;
  logic [7:0] b0;
  logic [7:0] b1;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  ecf_link_if link ();
  ecf_controller i_ecf_controller (.i_clk(i_clk), .i_nrst(i_nrst), .link(link.ctl),
    .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code), .i_cmd_param(cmd_param),
    .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_local_valid(local_valid), .o_local_code(local_code), .o_local_param(local_param),
    .o_enable_mask(enable_mask));
  ecf_expansion i_ecf_expansion (.i_clk(i_clk), .i_nrst(i_nrst), .link(link.exp),
    .i_move_x(move_x), .i_move_y(move_y), .o_marker_down(marker_down),
    .o_pos_setup(pos_setup), .o_marker_setup(marker_setup), .o_origin_x(origin_x),
    .o_origin_y(origin_y), .o_sample());
  ecf_link_chk i_ecf_link_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_fwd_line(link.fwd_line),
    .i_ret_o(link.ret_o), .i_ret_oe(link.ret_oe), .i_ret_line(link.ret_line));

  // The clock, and a cycle ceiling since a lost reply would hang the controller.
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 320000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic check(input logic [40:0] seen, input logic [40:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  // Valid is held until an edge that sees ready high has taken it.
  task automatic send_cmd(input logic [7:0] c, input logic [7:0] p);
    @(negedge i_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_param = p;
    while (cmd_ready !== 1'b1) @(negedge i_clk);
    @(negedge i_clk);
    cmd_valid = 1'b0;
  endtask : send_cmd

  // A missing answer is caught by the cycle ceiling.
  task automatic wait_ans(output logic [39:0] d, output logic l);
    while (local_valid !== 1'b1 && rsp_valid !== 1'b1) @(negedge i_clk);
    l = local_valid;
    d = local_valid ? {local_code, local_param, 24'h00_0000} : rsp_data;
  endtask : wait_ans

  // Samples one byte off the forward line in mid-bit, least significant bit first.
  task automatic rx_byte(output logic [7:0] b);
    int i;
    int k;
    for (k = 0; k < 100000 && link.fwd_line !== 1'b0; k++) @(negedge i_clk);
    repeat (ecf_pkg::HALF_CYC) @(negedge i_clk);
    for (i = 0; i < 8; i++) begin
      repeat (ecf_pkg::BIT_CYC) @(negedge i_clk);
      b[i] = link.fwd_line;
    end
    repeat (ecf_pkg::BIT_CYC) @(negedge i_clk);
    check({40'h0, link.fwd_line}, 41'h1, "stop bit");
  endtask : rx_byte

  task automatic complete_run();
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Local commands first, then one full reply, then a custom code that nobody answers.
  initial begin
    i_nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_param = 8'h00;
    move_x = 16'h1234;
    move_y = 16'hfedc;
    repeat (4) @(negedge i_clk);
    i_nrst = 1'b1;
    check({37'h0, cmd_ready, enable_mask}, 41'h8, "reset state");
    check({40'h0, link.fwd_line}, 41'h1, "idle line");
    send_cmd(8'h81, 8'h01);
    wait_ans(ans, loc);
    check({loc, ans}, {1'b1, 8'h81, 8'h01, 24'h00_0000}, "marker not local");
    for (int i = 0; i < 2; i++) begin
      send_cmd(i == 0 ? 8'hdb : 8'he6, 8'h5a);
      wait_ans(ans, loc);
      check({40'h0, loc}, 41'h1, "edge code not local");
    end
    send_cmd(ecf_pkg::EXPANSION_ENABLE_CMD, 8'h04);
    wait_ans(ans, loc);
    check({38'h0, enable_mask}, 41'h4, "enable mask");
    send_cmd(8'h42, 8'h00);
    wait_ans(ans, loc);
    check({loc, ans}, {1'b0, 40'h12_34fe_dc00}, "position reply");
    check({40'h0, marker_down}, 41'h0, "marker moved");
    send_cmd(8'he5, 8'ha5);
    rx_byte(b0);
    rx_byte(b1);
    check({25'h0, b0, b1}, {25'h0, 8'he5, 8'ha5}, "custom bytes");
    repeat (ecf_pkg::BIT_CYC) @(negedge i_clk);
    check({39'h0, cmd_ready, link.ret_oe}, 41'h0, "custom not held");
    check({1'b0, origin_x, origin_y, pos_setup}, 41'h0, "stray pair applied");
    check({33'h0, marker_setup}, 41'h0, "stray marker setup");
    complete_run();
  end
endmodule : tb

`default_nettype wire
